/* File: logic/vic_regs.sv */
`timescale 1ns/1ps
module vic_regs
   import vic_pkg::*;
#(
   parameter logic [31:0] EXT_SOURCES = 32'h0000_0001
) (
   input wire logic CLOCK_IN,
   input wire logic RST_IN,
   input wire logic [31:0] SOURCE_IN,
   output logic FAST_REQ_N_OUT,
   output logic NORMAL_REQ_N_OUT,
   output logic IRQ_OUT,
   input wire logic [11:0] AWADDR_IN,
   input wire logic AWVALID_IN,
   output logic AWREADY_OUT,
   input wire logic [31:0] WDATA_IN,
   input wire logic [3:0] WSTRB_IN,
   input wire logic WVALID_IN,
   output logic WREADY_OUT,
   output logic [1:0] BRESP_OUT,
   output logic BVALID_OUT,
   input wire logic BREADY_IN,
   input wire logic [11:0] ARADDR_IN,
   input wire logic ARVALID_IN,
   output logic ARREADY_OUT,
   output logic [31:0] RDATA_OUT,
   output logic [1:0] RRESP_OUT,
   output logic RVALID_OUT,
   input wire logic RREADY_IN
);

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   vic_mode_type source_mode_reg [VIC_NUM_SRC]; // Mode per source.
   logic [31:0] handler_address_reg [VIC_NUM_SRC]; // Handler table.
   logic [31:0] spurious_vector_reg; // Spurious handler address.
   logic [31:0] mask_reg; // One enable bit per source.
   logic [4:0] current_source_id; // Source now being serviced.
   wire [31:0] pending_reg; // One pending bit per source.
   logic [31:0] ack_bits; // Pending clears caused by the clear command and vector reads.
   logic fast_line_active; // Registered fast request.
   logic normal_line_active; // Registered normal request.
   logic [VIC_EVT_W-1:0] evt_status; // Sticky block events.
   logic [VIC_EVT_W-1:0] evt_enable; // Event enables.
   logic [VIC_EVT_W-1:0] evt_set; // Events this cycle.
   vic_pick_type pick; // Winner of the priority search.
   logic [2:0] best_prio; // Priority of the winner so far.

   // Write path state.
   vic_state_type wr_state;
   logic aw_held; // Write address captured.
   logic w_held; // Write data captured.
   logic [11:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_fire; // Both halves present: perform the write now.
   logic [31:0] wr_mask; // Byte enables spread to bits.
   logic [31:0] cmd_bits; // Command data under the byte enables.
   logic wr_known; // Write address is mapped.

   // Read path state.
   vic_state_type rd_state;
   logic rd_fire; // Read address taken this cycle.
   logic [31:0] rd_value;
   logic rd_known;

   // ---------------------------------------------------------------
   // Per-source input conditioning and pending state
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < VIC_NUM_SRC; g++) begin : g_src
         logic lvl; // Raw level, filtered for external sources only.
         logic active; // Level after polarity choice.
         logic prev; // Active level one cycle ago.
         logic pend; // Pending flag.
         logic invert; // Active-low or falling-edge selection.
         logic is_edge; // Edge rather than level sensitivity.
         if (EXT_SOURCES[g]) begin : g_ext
            logic s1;
            logic s2;
            logic s3;
            // A pin is resynchronised; the level only moves once the
            // second and third stages agree, which rejects a glitch
            // that got through the first stage.
            always_ff @(posedge CLOCK_IN) begin
               if (RST_IN) begin
                  s1 <= 1'b0;
                  s2 <= 1'b0;
                  s3 <= 1'b0;
                  lvl <= 1'b0;
               end else begin
                  s1 <= SOURCE_IN[g];
                  s2 <= s1;
                  s3 <= s2;
                  if (s2 == s3) begin
                     lvl <= s3;
                  end
               end
            end
         end else begin : g_int
            // Internal sources come from logic on this clock.
            assign lvl = SOURCE_IN[g];
         end
         // fixed internal polarity: only external sources may invert.
         assign invert = EXT_SOURCES[g] & ~source_mode_reg[g].trig[1];
         // edge codes: low trigger bit selects edge mode.
         assign is_edge = source_mode_reg[g].trig[0];
         assign active = lvl ^ invert;
         // Previous level for the edge detector.
         always_ff @(posedge CLOCK_IN) begin
            if (RST_IN) begin
               prev <= 1'b0;
            end else begin
               prev <= active;
            end
         end
         // level sources follow the input; clear acts on edges.
         // A new edge wins over a clear in the same cycle.
         always_ff @(posedge CLOCK_IN) begin
            if (RST_IN) begin
               pend <= 1'b0;
            end else if (!is_edge) begin
               pend <= active;
            end else if (active && !prev) begin
               pend <= 1'b1;
            end else if (ack_bits[g]) begin
               pend <= 1'b0;
            end
         end
         assign pending_reg[g] = pend;
      end
   endgenerate

   // ---------------------------------------------------------------
   // Priority search
   // ---------------------------------------------------------------
   // fast source skipped: it never enters the priority contest.
   // Ties go to the lower source number.
   always_comb begin
      pick = '0;
      best_prio = 3'h0;
      for (int i = 1; i < VIC_NUM_SRC; i++) begin
         if (pending_reg[i] && mask_reg[i] &&
             (!pick.found || source_mode_reg[i].prio > best_prio)) begin
            pick.found = 1'b1;
            pick.id = 5'(i);
            best_prio = source_mode_reg[i].prio;
         end
      end
   end

   // ---------------------------------------------------------------
   // Register bus: write path
   // ---------------------------------------------------------------
   assign AWREADY_OUT = !aw_held && (wr_state == VIC_IDLE);
   assign WREADY_OUT = !w_held && (wr_state == VIC_IDLE);
   assign wr_fire = aw_held && w_held && (wr_state == VIC_IDLE);
   assign wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                     {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   assign cmd_bits = wr_data & wr_mask;

   // Address and data are captured in either order, then written.
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wr_addr <= 12'h000;
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
      end else begin
         if (AWVALID_IN && AWREADY_OUT) begin
            aw_held <= 1'b1;
            wr_addr <= AWADDR_IN;
         end
         if (WVALID_IN && WREADY_OUT) begin
            w_held <= 1'b1;
            wr_data <= WDATA_IN;
            wr_strb <= WSTRB_IN;
         end
      end
   end

   // Writes to read-only readouts are accepted and ignored.
   always_comb begin
      wr_known = 1'b1;
      if (wr_addr[11:8] != 4'h0) begin
         case (wr_addr)
            VIC_NORMAL_VEC, VIC_FAST_VEC, VIC_CURRENT, VIC_PENDING,
            VIC_MASK, VIC_CORE, VIC_ENABLE_CMD, VIC_DISABLE_CMD,
            VIC_CLEAR_CMD, VIC_SPURIOUS, VIC_EVT_STATUS,
            VIC_EVT_ENABLE, VIC_EVT_CLEAR: wr_known = 1'b1;
            default: wr_known = 1'b0;
         endcase
      end
   end

   // Response: one write in flight, answered the cycle after it.
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         wr_state <= VIC_IDLE;
         BVALID_OUT <= 1'b0;
         BRESP_OUT <= VIC_RESP_OKAY;
      end else begin
         case (wr_state)
            VIC_IDLE: begin
               if (wr_fire) begin
                  wr_state <= VIC_RESP;
                  BVALID_OUT <= 1'b1;
                  BRESP_OUT <= wr_known ? VIC_RESP_OKAY : VIC_RESP_SLVERR;
               end
            end
            VIC_RESP: begin
               if (BREADY_IN) begin
                  wr_state <= VIC_IDLE;
                  BVALID_OUT <= 1'b0;
               end
            end
            default: wr_state <= VIC_IDLE;
         endcase
      end
   end

   // priority per source; the fast source keeps none.
   // handler table cleared at reset and written per byte lane.
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         for (int i = 0; i < VIC_NUM_SRC; i++) begin
            source_mode_reg[i] <= '0;
            handler_address_reg[i] <= VIC_VEC_RESET;
         end
      end else if (wr_fire && wr_addr[11:7] == VIC_MODE_BASE[11:7]) begin
         if (wr_strb[0]) begin
            source_mode_reg[wr_addr[6:2]].trig <=
               wr_data[VIC_TRIG_LSB +: 2];
            source_mode_reg[wr_addr[6:2]].prio <= (wr_addr[6:2] == 5'h00)
               ? 3'h0 : wr_data[VIC_PRIO_LSB +: 3];
         end
      end else if (wr_fire &&
                   wr_addr[11:7] == VIC_HANDLER_BASE[11:7]) begin
         handler_address_reg[wr_addr[6:2]] <=
            (handler_address_reg[wr_addr[6:2]] & ~wr_mask) |
            (wr_data & wr_mask);
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         spurious_vector_reg <= VIC_VEC_RESET;
      end else if (wr_fire && wr_addr == VIC_SPURIOUS) begin
         spurious_vector_reg <= (spurious_vector_reg & ~wr_mask) |
                                (wr_data & wr_mask);
      end
   end

   // enable sets; disable clears; zeros leave bits alone.
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         mask_reg <= VIC_MASK_RESET;
      end else if (wr_fire && wr_addr == VIC_ENABLE_CMD) begin
         mask_reg <= mask_reg | cmd_bits;
      end else if (wr_fire && wr_addr == VIC_DISABLE_CMD) begin
         mask_reg <= mask_reg & ~cmd_bits;
      end
   end

   // ---------------------------------------------------------------
   // Register bus: read path
   // ---------------------------------------------------------------
   assign ARREADY_OUT = (rd_state == VIC_IDLE);
   assign rd_fire = ARVALID_IN && ARREADY_OUT;

   // Read value for the offered address, before any side effect.
   always_comb begin
      rd_value = 32'h0000_0000;
      rd_known = 1'b1;
      if (ARADDR_IN[11:7] == VIC_MODE_BASE[11:7]) begin
         rd_value[VIC_TRIG_LSB +: 2] = source_mode_reg[ARADDR_IN[6:2]].trig;
         rd_value[VIC_PRIO_LSB +: 3] = source_mode_reg[ARADDR_IN[6:2]].prio;
      end else if (ARADDR_IN[11:7] == VIC_HANDLER_BASE[11:7]) begin
         rd_value = handler_address_reg[ARADDR_IN[6:2]];
      end else begin
         case (ARADDR_IN)
            VIC_NORMAL_VEC: rd_value = pick.found ?
               handler_address_reg[pick.id] : spurious_vector_reg;
            VIC_FAST_VEC: rd_value = (pending_reg[0] && mask_reg[0]) ?
               handler_address_reg[0] : spurious_vector_reg;
            VIC_CURRENT: rd_value[4:0] = current_source_id;
            VIC_PENDING: rd_value = pending_reg;
            VIC_MASK: rd_value = mask_reg;
            VIC_CORE: rd_value[1:0] = {normal_line_active,
                                       fast_line_active};
            VIC_SPURIOUS: rd_value = spurious_vector_reg;
            VIC_EVT_STATUS: rd_value[VIC_EVT_W-1:0] = evt_status;
            VIC_EVT_ENABLE: rd_value[VIC_EVT_W-1:0] = evt_enable;
            // Write-only commands read as zero.
            VIC_ENABLE_CMD, VIC_DISABLE_CMD, VIC_CLEAR_CMD,
            VIC_EVT_CLEAR: rd_value = 32'h0000_0000;
            default: rd_known = 1'b0;
         endcase
      end
   end

   // Read data is latched when taken and held until accepted.
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         rd_state <= VIC_IDLE;
         RVALID_OUT <= 1'b0;
         RDATA_OUT <= 32'h0000_0000;
         RRESP_OUT <= VIC_RESP_OKAY;
      end else begin
         case (rd_state)
            VIC_IDLE: begin
               if (rd_fire) begin
                  rd_state <= VIC_RESP;
                  RVALID_OUT <= 1'b1;
                  RDATA_OUT <= rd_value;
                  RRESP_OUT <= rd_known ? VIC_RESP_OKAY : VIC_RESP_SLVERR;
               end
            end
            VIC_RESP: begin
               if (RREADY_IN) begin
                  rd_state <= VIC_IDLE;
                  RVALID_OUT <= 1'b0;
               end
            end
            default: rd_state <= VIC_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Servicing and request lines
   // ---------------------------------------------------------------
   // clear command, plus the acknowledge that a vector read
   // gives, both drop the pending flag of an edge source only.
   always_comb begin
      ack_bits = 32'h0000_0000;
      if (wr_fire && wr_addr == VIC_CLEAR_CMD) begin
         ack_bits = cmd_bits;
      end
      if (rd_fire && ARADDR_IN == VIC_NORMAL_VEC && pick.found) begin
         ack_bits[pick.id] = 1'b1;
      end
      if (rd_fire && ARADDR_IN == VIC_FAST_VEC) begin
         ack_bits[0] = 1'b1;
      end
   end

   // the serviced number is taken on each normal vector read.
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         current_source_id <= 5'h00;
      end else if (rd_fire && ARADDR_IN == VIC_NORMAL_VEC) begin
         current_source_id <= pick.found ? pick.id : 5'h00;
      end
   end

   // Request lines are registered so the core sees no decode glitch.
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         fast_line_active <= 1'b0;
         normal_line_active <= 1'b0;
      end else begin
         fast_line_active <= pending_reg[0] & mask_reg[0];
         normal_line_active <= pick.found;
      end
   end
   assign FAST_REQ_N_OUT = ~fast_line_active;
   assign NORMAL_REQ_N_OUT = ~normal_line_active;

   // ---------------------------------------------------------------
   // Block events and interrupt output
   // ---------------------------------------------------------------
   always_comb begin
      evt_set = '0;
      evt_set[VIC_EVT_SPUR_NORMAL] = rd_fire &&
         ARADDR_IN == VIC_NORMAL_VEC && !pick.found;
      evt_set[VIC_EVT_SPUR_FAST] = rd_fire && ARADDR_IN == VIC_FAST_VEC &&
         !(pending_reg[0] && mask_reg[0]);
      evt_set[VIC_EVT_BAD_ADDR] = (rd_fire && !rd_known) ||
         (wr_fire && !wr_known);
   end

   // Sticky status: a new event wins over a clear in the same cycle.
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         evt_status <= '0;
      end else if (wr_fire && wr_addr == VIC_EVT_CLEAR) begin
         evt_status <= (evt_status & ~cmd_bits[VIC_EVT_W-1:0]) | evt_set;
      end else begin
         evt_status <= evt_status | evt_set;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         evt_enable <= '0;
      end else if (wr_fire && wr_addr == VIC_EVT_ENABLE) begin
         evt_enable <= (evt_enable & ~wr_mask[VIC_EVT_W-1:0]) |
                       cmd_bits[VIC_EVT_W-1:0];
      end
   end
   assign IRQ_OUT = |(evt_status & evt_enable);

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (RST_IN);

   a_enable_sets_mask: assert property (
      wr_fire && wr_addr == VIC_ENABLE_CMD |=>
      (mask_reg & $past(cmd_bits)) == $past(cmd_bits))
      else $error("enable command did not set mask bits");
   a_disable_clears: assert property (
      wr_fire && wr_addr == VIC_DISABLE_CMD |=>
      (mask_reg & $past(cmd_bits)) == 32'h0000_0000)
      else $error("disable command did not clear mask bits");
   a_normal_vector_hit: assert property (
      rd_fire && ARADDR_IN == VIC_NORMAL_VEC && pick.found |=>
      RVALID_OUT && RDATA_OUT == handler_address_reg[current_source_id])
      else $error("normal vector read returned wrong handler");
   a_normal_spurious: assert property (
      rd_fire && ARADDR_IN == VIC_NORMAL_VEC && !pick.found |=>
      RDATA_OUT == $past(spurious_vector_reg) && current_source_id == 0)
      else $error("spurious normal read returned wrong value");
   a_fast_vector: assert property (
      rd_fire && ARADDR_IN == VIC_FAST_VEC && pending_reg[0] &&
      mask_reg[0] |=> RDATA_OUT == $past(handler_address_reg[0]))
      else $error("fast vector read returned wrong handler");
   a_fast_spurious: assert property (
      rd_fire && ARADDR_IN == VIC_FAST_VEC &&
      !(pending_reg[0] && mask_reg[0]) |=>
      RDATA_OUT == $past(spurious_vector_reg))
      else $error("spurious fast read returned wrong value");
   a_core_mirror: assert property (
      pending_reg[0] && mask_reg[0] |=> !FAST_REQ_N_OUT)
      else $error("fast request line not raised");
   a_fast_no_prio: assert property (
      source_mode_reg[0].prio == 3'h0)
      else $error("fast source holds a priority");
   a_current_reset: assert property (
      $past(RST_IN) |-> current_source_id == 5'h00)
      else $error("current source not zero after reset");
   a_bvalid_holds: assert property (
      BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
      else $error("write response dropped before acceptance");

   c_normal_served: cover property (
      rd_fire && ARADDR_IN == VIC_NORMAL_VEC && pick.found);
   c_spurious_read: cover property (evt_set[VIC_EVT_SPUR_NORMAL]);
   c_fast_served: cover property (
      rd_fire && ARADDR_IN == VIC_FAST_VEC && pending_reg[0]);
   c_irq_raised: cover property ($rose(IRQ_OUT));

endmodule

/* File: logic/vic_pkg.sv */
// ----------------------------------------------------------------------
// Shared constants and types of the vectored interrupt controller.
// ----------------------------------------------------------------------
package vic_pkg;

   // Number of interrupt sources; source 0 is fast, 1 is the system one.
   localparam int VIC_NUM_SRC = 32;

   // Register byte offsets on the 12-bit register bus.
   localparam logic [11:0] VIC_MODE_BASE = 12'h000;
   localparam logic [11:0] VIC_HANDLER_BASE = 12'h080;
   localparam logic [11:0] VIC_NORMAL_VEC = 12'h100;
   localparam logic [11:0] VIC_FAST_VEC = 12'h104;
   localparam logic [11:0] VIC_CURRENT = 12'h108;
   localparam logic [11:0] VIC_PENDING = 12'h10c;
   localparam logic [11:0] VIC_MASK = 12'h110;
   localparam logic [11:0] VIC_CORE = 12'h114;
   localparam logic [11:0] VIC_ENABLE_CMD = 12'h120;
   localparam logic [11:0] VIC_DISABLE_CMD = 12'h124;
   localparam logic [11:0] VIC_CLEAR_CMD = 12'h128;
   localparam logic [11:0] VIC_SPURIOUS = 12'h134;
   localparam logic [11:0] VIC_EVT_STATUS = 12'h150;
   localparam logic [11:0] VIC_EVT_ENABLE = 12'h154;
   localparam logic [11:0] VIC_EVT_CLEAR = 12'h158;

   // Field positions inside a source mode register.
   localparam int VIC_PRIO_LSB = 0;
   localparam int VIC_TRIG_LSB = 5;

   // Values after reset.
   localparam logic [31:0] VIC_VEC_RESET = 32'h0000_0000;
   localparam logic [31:0] VIC_MASK_RESET = 32'h0000_0000;

   // Event bits of the block's own interrupt status register.
   localparam int VIC_EVT_W = 3;
   localparam int VIC_EVT_SPUR_NORMAL = 0;
   localparam int VIC_EVT_SPUR_FAST = 1;
   localparam int VIC_EVT_BAD_ADDR = 2;

   // Bus response codes.
   localparam logic [1:0] VIC_RESP_OKAY = 2'h0;
   localparam logic [1:0] VIC_RESP_SLVERR = 2'h2;

   // Stored part of one source mode register.
   typedef struct packed {
      logic [1:0] trig;
      logic [2:0] prio;
   } vic_mode_type;

   // Result of the priority search.
   typedef struct packed {
      logic found;
      logic [4:0] id;
   } vic_pick_type;

   // Response state of each bus direction.
   typedef enum logic {
      VIC_IDLE = 1'b0,
      VIC_RESP = 1'b1
   } vic_state_type;

endpackage

/* File: tb/vic_src_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Interrupt sources: peripherals and the external pin.
// ---------------------------------------------------------------
module vic_src_model (
   input wire logic clk_in,
   input wire logic [31:0] level_in,
   output logic [31:0] source_out
);
   // Pin 0 idles high, because its default trigger is active low.
   initial source_out = 32'h0000_0001;
   // Sources move just after the edge, as registered logic does.
   always @(posedge clk_in) begin
      source_out <= level_in;
   end
endmodule

/* File: tb/tb_vectored_interrupt_controller_regs.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Bench: register bus master, source model and read checks.
// ---------------------------------------------------------------
module tb_vectored_interrupt_controller_regs;
   import vic_pkg::*;
   logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
   logic [11:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, src = 32'h1, sp;
   logic [31:0] hv [0:3];
   logic [33:0] q [$];
   logic [1:0] wresp = 2'h0; // Response code of the last write.
   int fails = 0, check_count = 0;
   wire logic [31:0] src_w, rdat;
   wire logic awr, wrdy, bv, arr, rv, irq, fq, nq;
   wire logic [1:0] br, rr;
   vic_src_model i_src (.clk_in(clk), .level_in(src), .source_out(src_w));
   vic_regs i_dut (.CLOCK_IN(clk), .RST_IN(rst), .SOURCE_IN(src_w),
      .FAST_REQ_N_OUT(fq), .NORMAL_REQ_N_OUT(nq), .IRQ_OUT(irq),
      .AWADDR_IN(awa), .AWVALID_IN(awv), .AWREADY_OUT(awr),
      .WDATA_IN(wd), .WSTRB_IN(4'hf), .WVALID_IN(wv), .WREADY_OUT(wrdy),
      .BRESP_OUT(br), .BVALID_OUT(bv), .BREADY_IN(bre),
      .ARADDR_IN(ara), .ARVALID_IN(arv), .ARREADY_OUT(arr),
      .RDATA_OUT(rdat), .RRESP_OUT(rr), .RVALID_OUT(rv), .RREADY_IN(rre));
   always #5 clk = ~clk;
   task summarize;
      $display("Comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // A wait that never sees its answer counts as a mismatch.
   task tmo(input logic b);
      if (!b) begin
         fails++;
         summarize();
      end
   endtask
   // Each valid drops only at the edge where its ready was seen high.
   task wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      logic b;
      n = 0;
      b = 0;
      @(posedge clk);
      {awv, wv, bre} <= 3'h7;
      awa <= a;
      wd <= d;
      while (!b && n < 60) begin
         @(posedge clk);
         n++;
         awv <= awv & ~awr;
         wv <= wv & ~wrdy;
         b = bv;
         wresp = br;
      end
      bre <= 0;
      tmo(b);
   endtask
   // The expected answer is noted for the monitor before the request.
   task rd(input logic [11:0] a, input logic [33:0] e);
      int n;
      logic b;
      n = 0;
      b = 0;
      @(posedge clk);
      {arv, rre} <= 2'h3;
      ara <= a;
      q.push_back(e);
      while (!b && n < 60) begin
         @(posedge clk);
         n++;
         arv <= arv & ~arr;
         b = rv;
      end
      rre <= 0;
      tmo(b);
   endtask
   // Monitor: every accepted read answer meets the oldest note.
   always @(posedge clk) begin
      if (rv && rre) chk({rr, rdat}, q.pop_front());
   end
   initial begin
      sp = $urandom(32'h2afa);
      foreach (hv[i]) hv[i] = $urandom;
      sp = $urandom;
      repeat (3) @(posedge clk);
      rst <= 0;
      rd(VIC_MASK, 34'h0);
      rd(VIC_CURRENT, 34'h0);
      rd(VIC_HANDLER_BASE + 12'h14, 34'h0);
      rd(VIC_CORE, 34'h0);
      // Unmapped access raises event 2; enable, then clear it.
      wr(12'h200, 32'h0);
      chk({32'h0, wresp}, 34'h2);
      rd(VIC_EVT_STATUS, 34'h4);
      chk({33'h0, irq}, 34'h0);
      wr(VIC_EVT_ENABLE, 32'h4);
      chk({32'h0, wresp}, 34'h0);
      chk({33'h0, irq}, 34'h1);
      rd(12'h200, 34'h2_0000_0000);
      wr(VIC_EVT_CLEAR, 32'h4);
      chk({33'h0, irq}, 34'h0);
      for (int i = 0; i < 4; i++) wr(VIC_HANDLER_BASE + 12'(4 * i), hv[i]);
      wr(VIC_SPURIOUS, sp);
      rd(VIC_SPURIOUS, {2'h0, sp});
      rd(VIC_HANDLER_BASE + 12'h8, {2'h0, hv[2]});
      wr(VIC_MODE_BASE + 12'h8, 32'h65);
      wr(VIC_MODE_BASE + 12'hc, 32'h47);
      wr(VIC_MODE_BASE + 12'h10, 32'h20);
      rd(VIC_MODE_BASE + 12'h8, 34'h65);
      wr(VIC_ENABLE_CMD, 32'hc);
      wr(VIC_ENABLE_CMD, 32'h0);
      rd(VIC_MASK, 34'hc);
      // Filter and line latency are a few cycles; eight covers both.
      src <= 32'h1d;
      repeat (8) @(posedge clk);
      rd(VIC_PENDING, 34'h1c);
      rd(VIC_CORE, 34'h2);
      chk({32'h0, fq, nq}, 34'h2);
      wr(VIC_CLEAR_CMD, 32'h10);
      rd(VIC_PENDING, 34'hc);
      rd(VIC_NORMAL_VEC, {2'h0, hv[3]});
      rd(VIC_CURRENT, 34'h3);
      src <= 32'h1;
      repeat (8) @(posedge clk);
      rd(VIC_NORMAL_VEC, {2'h0, hv[2]});
      rd(VIC_PENDING, 34'h0);
      rd(VIC_NORMAL_VEC, {2'h0, sp});
      wr(VIC_ENABLE_CMD, 32'h1);
      src <= 32'h0;
      repeat (8) @(posedge clk);
      rd(VIC_CORE, 34'h1);
      chk({32'h0, fq, nq}, 34'h1);
      rd(VIC_FAST_VEC, {2'h0, hv[0]});
      src <= 32'h1;
      repeat (8) @(posedge clk);
      rd(VIC_FAST_VEC, {2'h0, sp});
      wr(VIC_DISABLE_CMD, 32'h9);
      rd(VIC_MASK, 34'h4);
      repeat (2) @(posedge clk);
      summarize();
   end
endmodule
